//--- src/usb_device_interrupt_logic.sv
// Interrupt mask and status logic of a full-speed USB device port
//
// Notes on behaviour
// - Writing one to disable endpoint bit clears that mask bit; zero does nothing.
// - Disable bits 8,9,10,11,13 clear bus-event mask bits; zero does nothing.
// - Mask register is read-only; one means enabled, zero disabled.
// - Host resume mask bit 9 is enabled after reset.
// - Endpoint status is high while any of its five flags is one.
// - Endpoint status stays until its endpoint flags are cleared.
// - Bus idle for 3 ms sets suspend status and enters suspend.
// - Host resume signalling sets the resume status bit.
// - In suspend, a rising edge on send-resume sets external resume status.
// - External resume with remote wake enabled drives resume signalling onto bus.
// - Each start-of-frame token sets the start-of-frame status bit.
// - End of bus reset sets status bit 12.
// - Host resume or reset sets wakeup status, held until cleared.
// - Writing one to enable bit sets that mask bit; zero does nothing.
// - Writing one to clear register event bit clears that status bit.
// - Clearing an endpoint's transmit-complete flag withdraws its interrupt share.
`timescale 1ns/1ns
module usb_device_interrupt_logic
    import usb_irq_pkg::*;
#(
    parameter int IDLE_LIMIT   = IDLE_CYCLES,
    parameter int RESUME_LIMIT = RESUME_CYCLES
) (
    input  wire logic               mclk,
    input  wire logic               rst,
    // Wishbone slave
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [7:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic      [31:0]        wb_dat_o,
    output logic                    wb_ack_o,
    // Per-endpoint flags from the endpoint control and status logic
    input  wire logic [NUM_EP-1:0]  setup_received,
    input  wire logic [NUM_EP-1:0]  rx_bank0_full,
    input  wire logic [NUM_EP-1:0]  rx_bank1_full,
    input  wire logic [NUM_EP-1:0]  tx_complete,
    input  wire logic [NUM_EP-1:0]  stall_acked,
    // Bus events from the serial engine, one-cycle pulses on mclk
    input  wire logic               bus_activity,
    input  wire logic               host_resume_det,
    input  wire logic               frame_start_det,
    input  wire logic               bus_reset_det,
    input  wire logic               bus_reset_end_det,
    // Asynchronous send-resume pin
    input  wire logic               send_resume,
    output logic                    suspended,
    output logic                    drive_resume,
    output logic                    irq
);

    logic [31:0]  mask_ff;
    logic [31:0]  event_ff;
    logic [31:0]  control_ff;
    logic         suspend_ff;
    logic         resume_sync;
    logic         resume_prev_ff;
    logic         idle_expired;
    logic [31:0]  resume_cnt_ff;
    logic [NUM_EP-1:0] ep_status;
    logic [31:0]  status;
    logic         wr_acc;
    logic         rd_acc;
    logic [31:0]  wr_bits;
    logic         ext_resume_evt;
    logic [31:0]  set_bits;

    // Byte lanes of the write data that sel enables
    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction : lane_mask

    // Write-one register hit test
    function automatic logic [31:0] hit(input logic [7:0] adr, input logic [7:0] ofs,
                                        input logic [31:0] bits);
        hit = (adr == ofs) ? bits : 32'h0000_0000;
    endfunction : hit

    assign wr_acc  = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign rd_acc  = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
    assign wr_bits = wr_acc ? (wb_dat_i & lane_mask(wb_sel_i)) : 32'h0000_0000;

    usb_sync2 #(
        .W (1)
    ) u_resume_sync (
        .mclk (mclk),
        .rst  (rst),
        .din  (send_resume),
        .dout (resume_sync)
    );

    usb_idle_timer #(
        .LIMIT (IDLE_LIMIT)
    ) u_idle (
        .mclk     (mclk),
        .rst      (rst),
        .activity (bus_activity),
        .expired  (idle_expired)
    );

    // Endpoint bits follow the endpoint flags, so they stay set until firmware clears the flags
    assign ep_status = setup_received | rx_bank0_full | rx_bank1_full
                     | tx_complete | stall_acked;

    assign status = event_ff | {24'h00_0000, ep_status};

    assign ext_resume_evt = suspend_ff && resume_sync && !resume_prev_ff;

    // Mask: enable sets, disable clears
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mask_ff <= MASK_RESET;
        end else begin
            mask_ff <= (mask_ff | hit(wb_adr_i, OFS_ENABLE, wr_bits & MASK_IMPL))
                     & ~hit(wb_adr_i, OFS_DISABLE, wr_bits & MASK_IMPL);
        end
    end

    // Event sources, placed at their bits of the status layout
    always_comb begin
        set_bits                  = 32'h0000_0000;
        set_bits[BIT_SUSPEND]     = idle_expired && !suspend_ff;
        set_bits[BIT_RESUME]      = host_resume_det;
        set_bits[BIT_EXT_RESUME]  = ext_resume_evt;
        set_bits[BIT_SOF]         = frame_start_det;
        set_bits[BIT_BUS_RST_END] = bus_reset_end_det;
        set_bits[BIT_WAKEUP]      = host_resume_det || bus_reset_det;
    end

    // Sticky bus-event status; a new event wins over a clear in the same cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            event_ff <= 32'h0000_0000;
        end else begin
            event_ff <= (event_ff & ~hit(wb_adr_i, OFS_CLEAR, wr_bits & EVENT_BITS))
                      | set_bits;
        end
    end

    // Suspend state: entered on idle, left on any bus activity or resume
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            suspend_ff     <= 1'b0;
            resume_prev_ff <= 1'b0;
        end else begin
            resume_prev_ff <= resume_sync;
            if (bus_activity || host_resume_det || bus_reset_det || drive_resume) begin
                suspend_ff <= 1'b0;
            end else if (idle_expired) begin
                suspend_ff <= 1'b1;
            end
        end
    end

    // Remote-wake control word, bit 0 enables remote wakeup
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            control_ff <= CONTROL_RESET;
        end else if (wr_acc && wb_adr_i == OFS_CONTROL && wb_sel_i[0]) begin
            control_ff <= {31'h0000_0000, wb_dat_i[BIT_REMOTE_WAKE]};
        end
    end

    // Resume signalling lasts a fixed time; the transceiver turns it into K-state
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            resume_cnt_ff <= 32'h0000_0000;
            drive_resume  <= 1'b0;
        end else if (ext_resume_evt && control_ff[BIT_REMOTE_WAKE]) begin
            resume_cnt_ff <= 32'(RESUME_LIMIT);
            drive_resume  <= 1'b1;
        end else if (resume_cnt_ff > 32'h0000_0001) begin
            resume_cnt_ff <= resume_cnt_ff - 32'h0000_0001;
        end else begin
            resume_cnt_ff <= 32'h0000_0000;
            drive_resume  <= 1'b0;
        end
    end

    // Bus answers one cycle after the request; reads only look, never clear
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wr_acc || rd_acc;
            if (rd_acc) begin
                unique case (wb_adr_i)
                    OFS_MASK:    wb_dat_o <= mask_ff & MASK_IMPL;
                    OFS_STATUS:  wb_dat_o <= status & STATUS_IMPL;
                    OFS_CONTROL: wb_dat_o <= control_ff;
                    default:     wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq       <= 1'b0;
            suspended <= 1'b0;
        end else begin
            irq       <= |(status & mask_ff & STATUS_IMPL);
            suspended <= suspend_ff;
        end
    end

endmodule : usb_device_interrupt_logic

//--- src/usb_irq_pkg.sv
// Register map, field positions and timing constants of the USB device interrupt logic
package usb_irq_pkg;

    localparam int          NUM_EP          = 8;
    localparam int          REG_W           = 32;

    // Byte offsets of the interrupt register group
    localparam logic [7:0]  OFS_ENABLE      = 8'h10;
    localparam logic [7:0]  OFS_DISABLE     = 8'h14;
    localparam logic [7:0]  OFS_MASK        = 8'h18;
    localparam logic [7:0]  OFS_STATUS      = 8'h1c;
    localparam logic [7:0]  OFS_CLEAR       = 8'h20;
    localparam logic [7:0]  OFS_CONTROL     = 8'h24;

    // Bit positions inside the mask and status layout and the control word
    localparam int          BIT_SUSPEND     = 8;
    localparam int          BIT_RESUME      = 9;
    localparam int          BIT_EXT_RESUME  = 10;
    localparam int          BIT_SOF         = 11;
    localparam int          BIT_BUS_RST_END = 12;
    localparam int          BIT_WAKEUP      = 13;
    localparam int          BIT_REMOTE_WAKE = 0;

    // Implemented bits and reset values of the registers
    localparam logic [31:0] MASK_IMPL       = 32'h0000_2fff;
    localparam logic [31:0] STATUS_IMPL     = 32'h0000_3fff;
    localparam logic [31:0] EVENT_BITS      = 32'h0000_3f00;
    localparam logic [31:0] MASK_RESET      = 32'h0000_0200;
    localparam logic [31:0] CONTROL_RESET   = 32'h0000_0000;

    // Idle time before suspend and length of resume signalling
    localparam int          CLK_HZ          = 50_000_000;
    localparam int          IDLE_US         = 3000;
    localparam int          IDLE_CYCLES     = (IDLE_US * (CLK_HZ / 1_000_000));
    localparam int          RESUME_US       = 10;
    localparam int          RESUME_CYCLES   = (RESUME_US * (CLK_HZ / 1_000_000));

endpackage : usb_irq_pkg

//--- src/usb_sync2.sv
// Two-stage synchroniser for a group of asynchronous inputs
`timescale 1ns/1ns
module usb_sync2 #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] meta_ff;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            meta_ff <= '0;
            dout    <= '0;
        end else begin
            meta_ff <= din;
            dout    <= meta_ff;
        end
    end

endmodule : usb_sync2

//--- src/usb_idle_timer.sv
// Bus idle counter: pulses once when the bus has been quiet for the full idle time
`timescale 1ns/1ns
module usb_idle_timer #(
    parameter int LIMIT = 150000
) (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic activity,
    output logic      expired
);

    localparam int CW = $clog2(LIMIT + 1);

    logic [CW-1:0] count_ff;
    logic          fired_ff;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            count_ff <= '0;
            fired_ff <= 1'b0;
            expired  <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (activity) begin
                count_ff <= '0;
                fired_ff <= 1'b0;
            end else if (count_ff != CW'(LIMIT)) begin
                count_ff <= count_ff + CW'(1);
            end else if (!fired_ff) begin
                // One pulse per idle period; re-armed only by new activity
                fired_ff <= 1'b1;
                expired  <= 1'b1;
            end
        end
    end

endmodule : usb_idle_timer

//--- test/usb_irq_properties.sv
// Port checker for the USB device interrupt logic
`timescale 1ns/1ns
module usb_irq_properties
    import usb_irq_pkg::*;
#(
    parameter int IDLE_LIMIT   = 150000,
    parameter int RESUME_LIMIT = 500
) (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        bus_activity,
    input wire logic        frame_start_det,
    input wire logic        suspended,
    input wire logic        drive_resume,
    input wire logic        irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic [31:0] msk_ff;
    int          idle_ff;
    int          drv_ff;
    wire         take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire         wen  = take && wb_we_i;
    wire [31:0]  wd   = wb_dat_i & {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                                    {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    // Shadow mask, so read-back is judged against the write history
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) msk_ff <= MASK_RESET;
        else if (wen && wb_adr_i == OFS_ENABLE) msk_ff <= msk_ff | (wd & MASK_IMPL);
        else if (wen && wb_adr_i == OFS_DISABLE) msk_ff <= msk_ff & ~wd;
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) idle_ff <= 0;
        else if (bus_activity) idle_ff <= 0;
        else idle_ff <= idle_ff + 1;
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) drv_ff <= 0;
        else if (drive_resume) drv_ff <= drv_ff + 1;
        else drv_ff <= 0;
    end
    a_ack_follows_req: assert property (take |=> wb_ack_o)
        else $error("request not acknowledged");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_mask_read_back: assert property (take && !wb_we_i && wb_adr_i == OFS_MASK
        |=> wb_dat_o == msk_ff) else $error("mask read-back wrong");
    a_unmapped_zero: assert property (take && !wb_we_i && wb_adr_i == 8'h00
        |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    a_sof_irq_rises: assert property (frame_start_det && msk_ff[BIT_SOF] && !wb_stb_i
        ##1 !wb_stb_i |=> irq) else $error("frame start gave no irq");
    a_masked_quiet: assert property ((msk_ff == 32'h0)[*2] |-> !irq)
        else $error("irq with all sources masked");
    a_resume_length: assert property ($fell(drive_resume) |-> drv_ff == RESUME_LIMIT)
        else $error("resume signalling length wrong");
    a_suspend_idle: assert property ($rose(suspended) |-> idle_ff == IDLE_LIMIT + 3)
        else $error("suspend before idle time");
    c_suspend: cover property ($rose(suspended));
    c_resume: cover property ($rose(drive_resume));
    c_disable: cover property (wen && wb_adr_i == OFS_DISABLE);
endmodule : usb_irq_properties

bind usb_device_interrupt_logic usb_irq_properties #(
    .IDLE_LIMIT  (IDLE_LIMIT),
    .RESUME_LIMIT(RESUME_LIMIT)
) i_usb_irq_properties (
    .mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .bus_activity(bus_activity), .frame_start_det(frame_start_det),
    .suspended(suspended), .drive_resume(drive_resume), .irq(irq)
);

//--- test/usb_host_model.sv
// Behavioural USB host: bus activity and signalling events, one cycle each
`timescale 1ns/1ns
module usb_host_model (
    input wire logic mclk,
    output logic     bus_activity,
    output logic     host_resume_det,
    output logic     frame_start_det,
    output logic     bus_reset_det,
    output logic     bus_reset_end_det
);
    logic [4:0] ev;
    assign {bus_activity, host_resume_det, frame_start_det, bus_reset_det, bus_reset_end_det} = ev;
    initial ev = 5'h00;
    // Code bits: activity, resume, frame start, reset, reset end
    task automatic send(input logic [4:0] code);
        @(posedge mclk);
        ev <= code;
        @(posedge mclk);
        ev <= 5'h00;
    endtask : send
endmodule : usb_host_model

//--- test/testbench.sv
// Self-checking bench for the USB device interrupt logic
`timescale 1ns/1ns
module testbench
    import usb_irq_pkg::*;
;
    typedef struct packed {
        logic [7:0]  wa;
        logic [3:0]  sel;
        logic [31:0] wd;
        logic [7:0]  ra;
        logic [31:0] rx;
    } row_t;
    logic        mclk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, send_resume;
    logic        bus_activity, host_resume_det, frame_start_det, bus_reset_det;
    logic        bus_reset_end_det, suspended, drive_resume, irq;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic [7:0]  fl [5];
    int          err_total, n_compared, n;
    logic [4:0]  evc [4] = '{5'h14, 5'h18, 5'h12, 5'h11};
    logic [31:0] evx [4] = '{32'h0800, 32'h2200, 32'h2000, 32'h1000};
    row_t        rows [11] = '{
        '{OFS_ENABLE,  4'hf, 32'hffff_ffff, OFS_MASK,    32'h0000_2fff},
        '{OFS_DISABLE, 4'hf, 32'h0000_00f0, OFS_MASK,    32'h0000_2f0f},
        '{OFS_DISABLE, 4'hf, 32'h0000_0000, OFS_MASK,    32'h0000_2f0f},
        '{OFS_DISABLE, 4'hf, 32'h0000_2f00, OFS_MASK,    32'h0000_000f},
        '{OFS_DISABLE, 4'hf, 32'hffff_ffff, OFS_MASK,    32'h0000_0000},
        '{OFS_ENABLE,  4'hf, 32'h0000_000f, OFS_MASK,    32'h0000_000f},
        '{OFS_ENABLE,  4'h1, 32'h0000_2f00, OFS_MASK,    32'h0000_000f},
        '{OFS_MASK,    4'hf, 32'hffff_ffff, OFS_MASK,    32'h0000_000f},
        '{OFS_CONTROL, 4'hf, 32'h0000_0001, OFS_CONTROL, 32'h0000_0001},
        '{8'h00,       4'hf, 32'hffff_ffff, 8'h00,       32'h0000_0000},
        '{OFS_STATUS,  4'hf, 32'hffff_ffff, OFS_STATUS,  32'h0000_0000}};

    usb_device_interrupt_logic #(.IDLE_LIMIT(300), .RESUME_LIMIT(5)) i_usb_device_interrupt_logic (
        .*, .setup_received(fl[0]), .rx_bank0_full(fl[1]), .rx_bank1_full(fl[2]),
        .tx_complete(fl[3]), .stall_acked(fl[4]));
    usb_host_model i_usb_host_model (.*);

    task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
                       input logic [31:0] d);
        int k;
        @(posedge mclk);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
        if (k >= 20) err_total++;
    endtask : bus

    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 4'hf, 32'h0);
    endtask : rd

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // Whole run is well under 3000 cycles
    initial begin
        repeat (5000) @(posedge mclk);
        err_total++;
        report_and_stop();
    end

    initial begin
        {rst, wb_cyc_i, wb_stb_i, wb_we_i, send_resume} = 5'b10000;
        {wb_adr_i, wb_sel_i, wb_dat_i} = 44'h0;
        fl = '{default: 8'h00};
        err_total = 0;
        n_compared = 0;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        rd(OFS_MASK);
        chk(q, MASK_RESET, "mask at reset");
        rd(OFS_STATUS);
        chk(q, 32'h0, "status at reset");
        foreach (rows[i]) begin
            bus(1'b1, rows[i].wa, rows[i].sel, rows[i].wd);
            rd(rows[i].ra);
            chk(q, rows[i].rx, "register read");
        end
        // Endpoint i raised by flag kind i; endpoint 4 stays masked
        for (int i = 0; i < 5; i++) begin
            fl[i] <= 8'h01 << i;
            rd(OFS_STATUS);
            chk(q, 32'h1 << i, "endpoint status");
            chk({31'h0, irq}, {31'h0, i < 4}, "endpoint irq");
            rd(OFS_STATUS);
            chk(q, 32'h1 << i, "endpoint sticky");
            fl[i] <= 8'h00;
            rd(OFS_STATUS);
            chk(q, 32'h0, "endpoint cleared");
        end
        bus(1'b1, OFS_ENABLE, 4'hf, 32'hffff_ffff);
        foreach (evc[i]) begin
            i_usb_host_model.send(evc[i]);
            rd(OFS_STATUS);
            chk(q, evx[i], "event status");
            chk({31'h0, irq}, {31'h0, |(evx[i] & MASK_IMPL)}, "event irq");
            bus(1'b1, OFS_CLEAR, 4'hf, 32'h0000_3f00);
            rd(OFS_STATUS);
            chk(q, 32'h0, "event cleared");
        end
        n = 0;
        while (suspended !== 1'b1 && n < 400) begin
            @(posedge mclk);
            n++;
        end
        chk({31'h0, suspended}, 32'h1, "suspended");
        rd(OFS_STATUS);
        chk(q, 32'h0000_0100, "suspend status");
        bus(1'b1, OFS_CLEAR, 4'hf, 32'h0000_3f00);
        send_resume <= 1'b1;
        n = 0;
        while (drive_resume !== 1'b1 && n < 20) begin
            @(posedge mclk);
            n++;
        end
        chk({31'h0, drive_resume}, 32'h1, "resume driven");
        rd(OFS_STATUS);
        chk(q, 32'h0000_0400, "external resume status");
        // Resume signalling lasts RESUME_LIMIT cycles
        repeat (8) @(posedge mclk);
        chk({31'h0, drive_resume}, 32'h0, "resume released");
        send_resume <= 1'b0;
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rd(OFS_MASK);
        chk(q, MASK_RESET, "mask after reset");
        rd(OFS_CONTROL);
        chk(q, CONTROL_RESET, "control after reset");
        // A send-resume edge while awake must raise nothing
        send_resume <= 1'b1;
        repeat (5) @(posedge mclk);
        rd(OFS_STATUS);
        chk(q, 32'h0, "no external resume awake");
        chk({31'h0, drive_resume}, 32'h0, "no resume awake");
        report_and_stop();
    end
endmodule : testbench
